/* test_timer0_watchdog_shared_prescaler.sv */
// bench for twp_top: scenario tasks over apb and the pin
// assumes twp_sw_model as the software side, short watchdog base count
module test_timer0_watchdog_shared_prescaler;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wd_en = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, pin, wd_rst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] cnt;
  int failures = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  twp_top #(.WDT_BASE_CYCLES(8)) i_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_ext_clock_pin(pin),
    .watchdog_enable(wd_en), .watchdog_reset(wd_rst), .count_value(cnt));
  twp_sw_model i_sw (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pin(pin));
  task automatic end_of_test;
    failures += i_sw.hangs;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    i_sw.xfer(1'b1, a, d, q, e);
    if (i_sw.hangs != 0) end_of_test();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic e;
    i_sw.xfer(1'b0, a, 32'h0, q, e);
    if (i_sw.hangs != 0) end_of_test();
    chk(q, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(12'h000, 32'h3F, 1'b0);
    rd(12'h004, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_edges;
    i_sw.set_pin(1'b1);
    chk(cnt, 32'h0);
    i_sw.set_pin(1'b0);
    chk(cnt, 32'h1);
    wr(12'h000, 32'h2F);
    i_sw.set_pin(1'b1);
    chk(cnt, 32'h2);
    i_sw.set_pin(1'b0);
    rd(12'h004, 32'h2, 1'b0);
    $display("t_edges done");
  endtask
  task automatic t_prescale;
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h20);
    repeat (4) begin
      i_sw.set_pin(1'b1);
      i_sw.set_pin(1'b0);
    end
    chk(cnt, 32'h2);
    $display("t_prescale done");
  endtask
  task automatic t_reassign;
    logic [7:0] c0;
    wr(12'h000, 32'h30);
    i_sw.set_pin(1'b1);
    wr(12'h004, 32'h0);
    // watchdog running and freshly cleared across the risky 1:1 return
    wd_en <= 1'b1;
    wr(12'h008, 32'h0);
    wr(12'h000, 32'h38);
    repeat (4) begin
      @(posedge clk);
      chk({31'h0, wd_rst}, 32'h0);
    end
    // off before the genuine base period would expire
    wd_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk(cnt, 32'h0);
    wr(12'h000, 32'h30);
    i_sw.safe_return(3'h0);
    // core source now counts every clock, straight past the prescaler
    c0 = cnt + 8'h04;
    repeat (4) @(posedge clk);
    chk(cnt, c0);
    rd(12'h00C, 32'h0, 1'b0);
    rd(12'h000, 32'h08, 1'b0);
    $display("t_reassign done");
  endtask
  task automatic t_watchdog;
    int n;
    wd_en <= 1'b1;
    wr(12'h008, 32'h0);
    n = 0;
    while (wd_rst !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      failures++;
      end_of_test();
    end
    chk({31'h0, n >= 8}, 32'h1);
    wd_en <= 1'b0;
    rd(12'h00C, 32'h1, 1'b0);
    wr(12'h00C, 32'h1);
    rd(12'h00C, 32'h0, 1'b0);
    $display("t_watchdog done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_edges();
    t_prescale();
    t_reassign();
    t_watchdog();
    end_of_test();
  end
endmodule

/* twp_defines.vh */
// constants for the timer0 / watchdog shared prescaler block
// assumes a single 250 MHz clock and 32-bit apb register access
`ifndef TWP_DEFINES_VH
`define TWP_DEFINES_VH

`define TWP_CLK_PERIOD_NS 4
`define TWP_WDT_BASE_NS 18000000
`define TWP_WDT_BASE_CYCLES (`TWP_WDT_BASE_NS / `TWP_CLK_PERIOD_NS)

`define TWP_ADDR_W 12
`define TWP_OFF_OPTION 12'h000
`define TWP_OFF_COUNT 12'h004
`define TWP_OFF_WDCLR 12'h008
`define TWP_OFF_STATUS 12'h00C

// option register fields
`define TWP_OPT_RATE_LSB 0
`define TWP_OPT_RATE_MSB 2
`define TWP_OPT_ASSIGN 3
`define TWP_OPT_EDGE 4
`define TWP_OPT_SRC 5
`define TWP_OPT_W 6
`define TWP_OPT_RESET 6'h3F

// status register fields
`define TWP_ST_WDT_TO 0
`define TWP_ST_CNT_OVF 1

`define TWP_PS_W 8
`define TWP_CNT_W 8
`define TWP_WDT_W 32

`endif

/* twp_prescaler.v */
// shared ripple prescaler: counts input ticks, emits one tick per 2^shift inputs
// assumes tick_in is a one-cycle pulse and clr overrides counting
`include "twp_defines.vh"

module twp_prescaler (
  input wire clk,
  input wire rst,
  input wire clr,
  input wire tick_in,
  input wire [3:0] shift,
  output wire tick_out
);

  reg [`TWP_PS_W-1:0] cnt_r;
  wire [`TWP_PS_W-1:0] mask;

  assign mask = ~({`TWP_PS_W{1'b1}} << shift);
  // shift of zero gives the 1:1 rate: every input tick passes
  assign tick_out = tick_in & ((cnt_r & mask) == mask);

  always @(posedge clk) begin
    if (rst || clr) begin
      cnt_r <= {`TWP_PS_W{1'b0}};
    end else if (tick_in) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

endmodule

/* twp_properties.sv */
// checker: timing relations seen at the ports of twp_top
// assumes it is bound to every twp_top instance, single clk domain
`include "twp_defines.vh"
module twp_properties #(
  parameter WDT_BASE_CYCLES = 8
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire watchdog_enable,
  input wire watchdog_reset,
  input wire [7:0] count_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] since_clr_r;
  wire wr_now = psel && penable && pwrite;
  // cycles since the last watchdog clear or enable
  always @(posedge clk) begin
    if (rst || !watchdog_enable || (wr_now && paddr == `TWP_OFF_WDCLR)) since_clr_r <= 32'h0;
    else since_clr_r <= since_clr_r + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  ////////////////////////////////////////////////////////////////
  a_reset_zero: assert property (rst |=> count_value == 8'h00 && !watchdog_reset)
    else $error("count or watchdog reset not cleared");
  a_step_one: assert property (disable iff (rst)
    $changed(count_value) && !$past(wr_now) && !$past(rst)
    |-> count_value == $past(count_value) + 8'h01) else $error("count jumped");
  a_pulse_once: assert property (disable iff (rst) watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  a_min_timeout: assert property (disable iff (rst)
    watchdog_reset |-> since_clr_r >= WDT_BASE_CYCLES) else $error("early watchdog reset");
  a_off_quiet: assert property (disable iff (rst)
    !watchdog_enable ##1 !watchdog_enable |-> !watchdog_reset) else $error("reset while off");
  a_err_phase: assert property (disable iff (rst) pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_ready_high: assert property (disable iff (rst) psel && penable |-> pready)
    else $error("wait state inserted");
endmodule
bind twp_top twp_properties #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES)) i_props (.clk(clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .watchdog_enable(watchdog_enable),
  .watchdog_reset(watchdog_reset), .count_value(count_value));

/* twp_sw_model.sv */
// software side: apb master and the external timer clock pin
// assumes clk from the bench; pin is changed just after a rising edge
module twp_sw_model (
  input logic clk,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int hangs = 0;
  // bus idle and pin low until the first task call
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin = 1'b0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hangs++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_pin(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (4) @(posedge clk);
  endtask
  // pin source off, edge away from pin level, no 1:1 until cleared
  task automatic safe_return(input logic [2:0] rate);
    logic [31:0] q;
    logic e;
    xfer(1'b1, 12'h000, {26'h0, 1'b0, ~pin, 4'h1}, q, e);
    xfer(1'b1, 12'h000, {26'h0, 1'b0, ~pin, 4'h9}, q, e);
    xfer(1'b1, 12'h008, 32'h0, q, e);
    xfer(1'b1, 12'h000, {26'h0, 1'b0, ~pin, 1'b1, rate}, q, e);
  endtask
endmodule

/* twp_top.v */
// timer0 counter and watchdog sharing one prescaler, with apb registers
// assumes the external clock pin is already synchronous to clk
//
// Behaviour
// - after reset the prescaler belongs to the watchdog, not timer0
// - timer0 on external source with prescaler advances on active pin edges
// - reset selects the external clock pin as timer0 source
// - edge select set picks falling edge, clear picks rising edge
// - moving the prescaler back to watchdog must not inject a clock pulse
// - at 1:1 rate, reassignment never causes a false watchdog reset
//
// Local design decisions: the address map and register access over APB.
`include "twp_defines.vh"

module twp_top #(
  parameter WDT_BASE_CYCLES = `TWP_WDT_BASE_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TWP_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire timer_ext_clock_pin,
  input wire watchdog_enable,
  output wire watchdog_reset,
  output wire [`TWP_CNT_W-1:0] count_value
);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup_ph;
  wire access_ph;
  wire wr_en;
  wire hit_opt;
  wire hit_cnt;
  wire hit_clr;
  wire hit_st;
  wire mapped;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_opt = (paddr == `TWP_OFF_OPTION);
  assign hit_cnt = (paddr == `TWP_OFF_COUNT);
  assign hit_clr = (paddr == `TWP_OFF_WDCLR);
  assign hit_st = (paddr == `TWP_OFF_STATUS);
  assign mapped = hit_opt | hit_cnt | hit_clr | hit_st;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign wr_en = access_ph & pwrite & mapped;

  ////////////////////////////////////////////////////////////////////////////
  // option register

  reg [`TWP_OPT_W-1:0] opt_r;
  wire [2:0] rate;
  wire to_wdt;
  wire edge_fall;
  wire src_pin;

  assign rate = opt_r[`TWP_OPT_RATE_MSB:`TWP_OPT_RATE_LSB];
  assign to_wdt = opt_r[`TWP_OPT_ASSIGN];
  assign edge_fall = opt_r[`TWP_OPT_EDGE];
  assign src_pin = opt_r[`TWP_OPT_SRC];

  always @(posedge clk) begin
    if (rst) begin
      opt_r <= `TWP_OPT_RESET;
    end else if (wr_en && hit_opt) begin
      opt_r <= pwdata[`TWP_OPT_W-1:0];
    end
  end

  // an assignment change is seen as a level change, used to clear the prescaler and to mask its input ticks
  reg to_wdt_d_r;
  wire assign_chg;

  always @(posedge clk) begin
    if (rst) begin
      to_wdt_d_r <= 1'b1;
    end else begin
      to_wdt_d_r <= to_wdt;
    end
  end

  assign assign_chg = to_wdt ^ to_wdt_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // external pin edge detection

  reg pin_d_r;
  wire pin_rise;
  wire pin_fall;
  wire pin_edge;
  wire cnt_src_tick;

  // no reset: the delayed copy follows the pin even in reset, so a pin
  // held high through reset cannot fake a rising edge afterwards
  always @(posedge clk) begin
    pin_d_r <= timer_ext_clock_pin;
  end

  assign pin_rise = timer_ext_clock_pin & ~pin_d_r;
  assign pin_fall = ~timer_ext_clock_pin & pin_d_r;
  assign pin_edge = edge_fall ? pin_fall : pin_rise;
  // internal source counts every core clock
  assign cnt_src_tick = src_pin ? pin_edge : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog base period

  reg [`TWP_WDT_W-1:0] base_r;
  wire base_tick;
  wire wd_clear;

  assign wd_clear = wr_en & hit_clr;
  assign base_tick = watchdog_enable && (base_r == WDT_BASE_CYCLES - 1);

  always @(posedge clk) begin
    if (rst || wd_clear || !watchdog_enable || base_tick) begin
      base_r <= {`TWP_WDT_W{1'b0}};
    end else begin
      base_r <= base_r + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared prescaler
  // the mux picks one-cycle ticks, never clock levels, so a change of
  // assignment cannot itself look like an edge whatever the pin level is

  wire ps_in;
  wire ps_out;
  wire ps_clr;
  wire [3:0] ps_shift;

  assign ps_in = to_wdt ? base_tick : cnt_src_tick;
  // reassignment clears the prescaler instead of clocking it
  assign ps_clr = assign_chg | (wr_en & hit_cnt & ~to_wdt) | (wd_clear & to_wdt);
  // ticks arriving in the switch cycle are dropped together with the clear
  assign ps_shift = to_wdt ? {1'b0, rate} : ({1'b0, rate} + 4'h1);

  twp_prescaler u_ps (
    .clk(clk),
    .rst(rst),
    .clr(ps_clr),
    .tick_in(ps_in & ~assign_chg),
    .shift(ps_shift),
    .tick_out(ps_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // timer0 counter

  reg [`TWP_CNT_W-1:0] cnt_r;
  wire cnt_tick;
  wire cnt_ovf;

  assign cnt_tick = to_wdt ? cnt_src_tick : ps_out;
  assign cnt_ovf = cnt_tick & (cnt_r == 8'hFF) & ~(wr_en & hit_cnt);

  always @(posedge clk) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else if (wr_en && hit_cnt) begin
      cnt_r <= pwdata[`TWP_CNT_W-1:0];
    end else if (cnt_tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign count_value = cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog time-out

  reg wdt_rst_r;
  wire wdt_to;

  // only a real base period expiry can time out, never a reassignment
  assign wdt_to = watchdog_enable & ~wd_clear & (to_wdt ? ps_out : base_tick);

  always @(posedge clk) begin
    if (rst) begin
      wdt_rst_r <= 1'b0;
    end else begin
      wdt_rst_r <= wdt_to;
    end
  end

  assign watchdog_reset = wdt_rst_r;

  ////////////////////////////////////////////////////////////////////////////
  // status flags: write one to clear, a new event wins over the clear

  reg st_to_r;
  reg st_ovf_r;
  wire st_wr;

  assign st_wr = wr_en & hit_st;

  always @(posedge clk) begin
    if (rst) begin
      st_to_r <= 1'b0;
      st_ovf_r <= 1'b0;
    end else begin
      st_to_r <= wdt_to | (st_to_r & ~(st_wr & pwdata[`TWP_ST_WDT_TO]));
      st_ovf_r <= cnt_ovf | (st_ovf_r & ~(st_wr & pwdata[`TWP_ST_CNT_OVF]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle for a zero-wait access

  reg [31:0] prdata_r;
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_opt) begin
      rd_mux[`TWP_OPT_W-1:0] = opt_r;
    end else if (hit_cnt) begin
      rd_mux[`TWP_CNT_W-1:0] = cnt_r;
    end else if (hit_st) begin
      rd_mux[`TWP_ST_WDT_TO] = st_to_r;
      rd_mux[`TWP_ST_CNT_OVF] = st_ovf_r;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      prdata_r <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;

endmodule
